//--- hdl/sepi_map.vh
`ifndef SEPI_MAP_VH
`define SEPI_MAP_VH
// instruction codes, bit 3 is don't care
`define SEPI_OP_SET_LATCH  8'h06
`define SEPI_OP_WRDI       8'h04
`define SEPI_OP_RDSR       8'h05
`define SEPI_OP_STAT_WR    8'h01
`define SEPI_OP_READ       8'h03
`define SEPI_OP_WRITE      8'h02
`define SEPI_OP_MASK       8'hF7
// status register layout
`define SEPI_SR_LATCH_BIT  1
`define SEPI_SR_WIP_BIT    0
`define SEPI_SR_HIGH_ONES  4'hF
// phases
`define SEPI_PH_CMD        3'h0
`define SEPI_PH_ADDR       3'h1
`define SEPI_PH_WDATA      3'h2
`define SEPI_PH_RDATA      3'h3
`define SEPI_PH_SRDATA     3'h4
`define SEPI_PH_SRWR       3'h5
`define SEPI_PH_DEAD       3'h6
// write time
`define SEPI_T_WRITE_NS    4000000
`define SEPI_CLK_PERIOD_NS 4
`endif

//--- hdl/sepi_core.v
//
// Behaviour
// - chip select high floats output, deselects
// - deselect gives standby unless write busy
// - sample input on rising clock, selected, unheld
// - change output only on falling clock
// - instruction, address, data decoded in order
// - write protect low clears write latch
// - write protect low blocks nonvolatile writes
// - hold pauses transfer, keeps progress
// - hold floats output, ignores clock, input
// - latch set only by enable; else reject
// - msb first opcode; invalid code ignored until deselect
//
`timescale 1ns/1ps
`include "sepi_map.vh"

module sepi_core #(
  parameter integer WRITE_CYCLES = `SEPI_T_WRITE_NS / `SEPI_CLK_PERIOD_NS,
  parameter integer AW           = 9
) (
  // clock and reset
  input  wire          sys_clk,
  input  wire          rst,
  // serial pins
  input  wire          cs_n,
  input  wire          sck,
  input  wire          si,
  input  wire          hold_n,
  input  wire          wp_n,
  output reg           so_q,
  output reg           so_oe_n_q,
  // array side
  output reg  [AW-1:0] mem_addr_q,
  output reg  [7:0]    mem_wdata_q,
  output reg           mem_we_q,
  input  wire [7:0]    mem_rdata,
  output reg  [1:0]    block_prot_q,
  // status
  output reg           write_enable_latch_bit_q,
  output reg           busy_q,
  output reg           standby_q
);

  // ***********************************************
  // input synchronisers
  // ***********************************************
  reg [4:0] meta_q;
  reg [4:0] sync_q;
  reg       sck_prev_q;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q     <= 5'h13;
      sync_q     <= 5'h13;
      sck_prev_q <= 1'b0;
    end else begin
      meta_q     <= {cs_n, sck, si, hold_n, wp_n};
      sync_q     <= meta_q;
      sck_prev_q <= sync_q[3];
    end
  end
  wire cs_s   = sync_q[4];
  wire sck_s  = sync_q[3];
  wire si_s   = sync_q[2];
  wire hold_s = sync_q[1];
  wire wp_s   = sync_q[0];
  wire held   = ~hold_s;
  wire rise   = ~cs_s & ~held & sck_s & ~sck_prev_q;
  wire fall   = ~cs_s & ~held & ~sck_s & sck_prev_q;

  // ***********************************************
  // shifter and phases
  // ***********************************************
  reg [2:0]    ph_q;
  reg [2:0]    cnt_q;
  reg [7:0]    sh_q;
  reg [7:0]    op_q;
  reg [7:0]    obuf_q;
  reg          wr_pend_q;
  reg          sr_pend_q;
  reg [1:0]    sr_new_q;
  reg          go_q;
  reg          ld_q;
  reg          drv_q;
  reg [31:0]   wcnt_q;
  wire [7:0]   byte_in = {sh_q[6:0], si_s};
  wire         last    = (cnt_q == 3'h7);
  wire [7:0]   opm     = byte_in & `SEPI_OP_MASK;
  wire [7:0]   sr_val  = {`SEPI_SR_HIGH_ONES, block_prot_q,
                          write_enable_latch_bit_q, busy_q};

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ph_q <= `SEPI_PH_CMD;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      op_q <= 8'h00;
      obuf_q <= 8'h00;
      mem_addr_q <= {AW{1'b0}};
      mem_wdata_q <= 8'h00;
      mem_we_q <= 1'b0;
      wr_pend_q <= 1'b0;
      sr_pend_q <= 1'b0;
      sr_new_q <= 2'h0;
      go_q <= 1'b0;
      ld_q <= 1'b0;
      drv_q <= 1'b0;
      busy_q <= 1'b0;
      wcnt_q <= 32'h0;
      block_prot_q <= 2'h0;
      write_enable_latch_bit_q <= 1'b0;
      so_q <= 1'b0;
      so_oe_n_q <= 1'b1;
      standby_q <= 1'b1;
    end else begin
      mem_we_q <= 1'b0;
      go_q <= 1'b0;
      // read byte fetched once address settles
      ld_q <= rise & last & (((ph_q == `SEPI_PH_ADDR) & (op_q[1:0] == 2'h3)) |
                             (ph_q == `SEPI_PH_RDATA));
      standby_q <= cs_s & ~busy_q & ~go_q;
      if (cs_s) begin
        ph_q <= `SEPI_PH_CMD;
        cnt_q <= 3'h0;
        so_oe_n_q <= 1'b1;
        drv_q <= 1'b0;
        if ((wr_pend_q | sr_pend_q) & ~busy_q & ~go_q) begin
          go_q <= 1'b1;
        end
      end else if (held) begin
        so_oe_n_q <= 1'b1;
      end else if (fall) begin
        if (ph_q == `SEPI_PH_RDATA || ph_q == `SEPI_PH_SRDATA) begin
          so_q <= obuf_q[7];
          obuf_q <= {obuf_q[6:0], 1'b0};
          so_oe_n_q <= 1'b0;
          drv_q <= 1'b1;
        end else begin
          so_oe_n_q <= 1'b1;
          drv_q <= 1'b0;
        end
      end else if (rise) begin
        sh_q <= byte_in;
        cnt_q <= cnt_q + 3'h1;
        if (ph_q == `SEPI_PH_CMD && last) begin
          op_q <= byte_in;
          case (opm)
            `SEPI_OP_SET_LATCH: ph_q <= `SEPI_PH_DEAD;
            `SEPI_OP_WRDI: begin
              write_enable_latch_bit_q <= 1'b0;
              ph_q <= `SEPI_PH_DEAD;
            end
            `SEPI_OP_RDSR: begin
              obuf_q <= sr_val;
              ph_q <= `SEPI_PH_SRDATA;
            end
            `SEPI_OP_STAT_WR: ph_q <= `SEPI_PH_SRWR;
            `SEPI_OP_READ, `SEPI_OP_WRITE: ph_q <= `SEPI_PH_ADDR;
            default: ph_q <= `SEPI_PH_DEAD;
          endcase
        end else if (ph_q == `SEPI_PH_ADDR && last) begin
          mem_addr_q <= {op_q[3], byte_in};
          ph_q <= (op_q[1:0] == 2'h3) ? `SEPI_PH_RDATA : `SEPI_PH_WDATA;
        end else if (ph_q == `SEPI_PH_RDATA && last) begin
          mem_addr_q <= mem_addr_q + {{(AW-1){1'b0}}, 1'b1};
        end else if (ph_q == `SEPI_PH_SRDATA && last) begin
          obuf_q <= sr_val;
        end else if (ph_q == `SEPI_PH_WDATA && last) begin
          if (write_enable_latch_bit_q & wp_s & ~busy_q) begin
            mem_wdata_q <= byte_in;
            wr_pend_q <= 1'b1;
          end
          ph_q <= `SEPI_PH_DEAD;
        end else if (ph_q == `SEPI_PH_SRWR && last) begin
          if (write_enable_latch_bit_q & wp_s & ~busy_q) begin
            sr_new_q <= byte_in[3:2];
            sr_pend_q <= 1'b1;
          end
          ph_q <= `SEPI_PH_DEAD;
        end
      end else begin
        so_oe_n_q <= ~drv_q;
      end
      if (ld_q) begin
        obuf_q <= mem_rdata;
      end
      // latch set when the clock count is a multiple of 8
      if (cs_s && ph_q == `SEPI_PH_DEAD && cnt_q == 3'h0 &&
          (op_q & `SEPI_OP_MASK) == `SEPI_OP_SET_LATCH && ~busy_q) begin
        write_enable_latch_bit_q <= 1'b1;
        op_q <= 8'h00;
      end
      if (go_q) begin
        busy_q <= 1'b1;
        wcnt_q <= 32'h0;
        if (wr_pend_q) begin
          mem_we_q <= 1'b1;
        end
        if (sr_pend_q) begin
          block_prot_q <= sr_new_q;
        end
        wr_pend_q <= 1'b0;
        sr_pend_q <= 1'b0;
      end else if (busy_q) begin
        wcnt_q <= wcnt_q + 32'h1;
        if (wcnt_q == WRITE_CYCLES - 1) begin
          busy_q <= 1'b0;
          write_enable_latch_bit_q <= 1'b0;
        end
      end
      if (~wp_s) begin
        write_enable_latch_bit_q <= 1'b0;
      end
    end
  end

endmodule // sepi_core

//--- verif/sepi_core_sva.sv
`timescale 1ns/1ps
module sepi_core_sva (
  input wire sys_clk,
  input wire rst,
  input wire cs_n,
  input wire sck,
  input wire hold_n,
  input wire wp_n,
  input wire so_q,
  input wire so_oe_n_q,
  input wire mem_we_q,
  input wire write_enable_latch_bit_q,
  input wire busy_q,
  input wire standby_q
);
  // ****
  // pin checks
  // ****
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence busy_run; busy_q[*8]; endsequence
  cs_float_a: assert property (cs_n[*5] |-> so_oe_n_q) else $error("so driven");
  hold_float_a: assert property ((!hold_n)[*5] |-> so_oe_n_q) else $error("so in hold");
  so_launch_a: assert property ((sck && !cs_n)[*6] |-> $stable(so_q)) else $error("so moved");
  wp_clear_a: assert property ((!wp_n)[*5] |-> !write_enable_latch_bit_q) else $error("latch");
  wp_block_a: assert property ((!wp_n)[*8] |-> !mem_we_q) else $error("write under wp");
  write_busy_a: assert property (mem_we_q |-> ##[0:1] busy_run) else $error("no busy");
  idle_stby_a: assert property ((cs_n && !busy_q)[*5] |-> standby_q) else $error("stby");
  busy_stby_a: assert property (busy_q |-> !standby_q) else $error("stby busy");
  latch_set_a: assert property ($rose(write_enable_latch_bit_q) |-> cs_n && wp_n) else $error("set");
endmodule // sepi_core_sva

//--- verif/sepi_host_model.sv
`timescale 1ns/1ps
module sepi_host_model (
  // clock
  input  wire sys_clk,
  // pins
  input  wire so,
  input  wire so_oe_n,
  output reg  cs_n,
  output reg  sck,
  output reg  si,
  output reg  hold_n
);
  // ****
  // spi host
  // ****
  initial begin
    cs_n = 1'h1; sck = 1'h0; si = 1'h0; hold_n = 1'h1;
  end
  task half; repeat (20) @(negedge sys_clk); endtask
  task sel(input reg lvl); begin half; cs_n = lvl; half; end endtask
  // hold inside a frame, sck low around it
  task hold(input reg lvl); begin half; hold_n = lvl; half; end endtask
  task desel; cs_n = 1'h1; endtask
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      rx = 8'h00;
      for (i = 7; i >= 0; i = i - 1) begin
        si = tx[i]; half; sck = 1'h1;
        // released line shows inverse
        rx = {rx[6:0], so_oe_n ? ~rx[0] : so};
        half; sck = 1'h0;
      end
    end
  endtask
endmodule // sepi_host_model

//--- verif/sepi_core_tb_top.sv
`timescale 1ns/1ps
module sepi_core_tb_top;
  reg          sys_clk, rst, wp_n;
  reg  [7:0]   rx, wd;
  reg  [8:0]   wa;
  integer      failures, n_tests, nw, i;
  wire         cs_n, sck, si, hold_n, so_q, so_oe_n_q, mem_we_q, wlatch, busy_q, standby_q;
  wire [8:0]   mem_addr_q;
  wire [7:0]   mem_wdata_q;
  wire [1:0]   bp;
  wire [7:0]   mem_rdata = ~mem_addr_q[7:0];
  // ****
  // harness
  // ****
  sepi_core #(.WRITE_CYCLES(40)) dut (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .sck(sck),
    .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_q(so_q), .so_oe_n_q(so_oe_n_q),
    .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_we_q(mem_we_q),
    .mem_rdata(mem_rdata), .block_prot_q(bp), .write_enable_latch_bit_q(wlatch),
    .busy_q(busy_q), .standby_q(standby_q));
  sepi_host_model h (.sys_clk(sys_clk), .so(so_q), .so_oe_n(so_oe_n_q), .cs_n(cs_n),
    .sck(sck), .si(si), .hold_n(hold_n));
  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (mem_we_q === 1'h1) begin
    wa <= mem_addr_q; wd <= mem_wdata_q; nw <= nw + 1;
  end
  task chk(input [8:0] seen, input [8:0] exp, input [63:0] nm); begin
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("Error %0s exp %h seen %h", nm, exp, seen);
    end
  end endtask
  task close_out; begin
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end endtask
  task set_latch; begin h.sel(1'h0); h.xfer(8'h06, rx); h.sel(1'h1); end endtask
  task wait_idle; begin
    for (i = 0; i < 100 && busy_q !== 1'h0; i = i + 1) @(negedge sys_clk);
    if (busy_q !== 1'h0) begin failures = failures + 1; close_out; end
  end endtask
  task wr3; begin
    h.sel(1'h0); h.xfer(8'h02, rx); h.xfer(8'h5A, rx); h.xfer(8'hC3, rx); h.half;
  end endtask
  task t_write; begin
    set_latch; chk(wlatch, 9'h1, "latch");
    wr3; h.desel; repeat (8) @(negedge sys_clk);
    chk(busy_q, 9'h1, "busy"); chk(standby_q, 9'h0, "stby");
    wait_idle;
    h.half; chk(standby_q, 9'h1, "stby"); chk(wlatch, 9'h0, "wlclr");
    chk(wa, 9'h05A, "waddr"); chk(wd, 9'h0C3, "wdata");
    wr3; h.sel(1'h1); chk(nw, 9'h1, "nolatch");
    $display("write done");
  end endtask
  task t_status; begin
    set_latch; h.sel(1'h0); h.xfer(8'h05, rx); h.xfer(8'h00, rx);
    chk(rx, 9'h0F2, "rdsr");
    h.xfer(8'h00, rx); chk(rx, 9'h0F2, "rdsr2"); h.sel(1'h1);
    h.sel(1'h0); h.xfer(8'h01, rx); h.xfer(8'h0C, rx); h.sel(1'h1); wait_idle;
    chk(bp, 9'h003, "bpset"); chk(wlatch, 9'h0, "srwel");
    set_latch; h.sel(1'h0); h.xfer(8'h04, rx); h.sel(1'h1);
    chk(wlatch, 9'h0, "wrdi");
    h.sel(1'h0); h.xfer(8'h05, rx); h.xfer(8'h00, rx); h.sel(1'h1);
    chk(rx, 9'h0FC, "rdsr3");
    $display("status done");
  end endtask
  task t_read(input [7:0] a, input reg hld); begin
    h.sel(1'h0); h.xfer(8'h03, rx); chk(so_oe_n_q, 9'h1, "cmdz");
    h.xfer(a, rx);
    if (hld) begin
      h.hold(1'h0); h.xfer(8'hFF, rx); chk(so_oe_n_q, 9'h1, "holdz");
      h.hold(1'h1);
    end
    h.xfer(8'h00, rx); chk(rx, {~a}, "rd0");
    h.xfer(8'h00, rx); chk(rx, {~(a + 8'h01)}, "rd1");
    h.sel(1'h1); chk(so_oe_n_q, 9'h1, "csz");
    $display("read done");
  end endtask
  task t_wp; begin
    set_latch; @(negedge sys_clk) wp_n = 1'h0; repeat (6) @(negedge sys_clk);
    chk(wlatch, 9'h0, "wpclr");
    set_latch; wr3; h.sel(1'h1); chk(nw, 9'h1, "wpwr");
    t_read(8'h7F, 1'h0); wp_n = 1'h1;
    h.sel(1'h0); h.xfer(8'hFF, rx); h.xfer(8'h05, rx); h.half;
    chk(so_oe_n_q, 9'h1, "badop"); h.sel(1'h1);
    $display("protect done");
  end endtask
  initial begin
    failures = 0; n_tests = 0; nw = 0; wp_n = 1'h1; rst = 1'h1;
    repeat (8) @(negedge sys_clk);
    rst = 1'h0;
    repeat (4) @(negedge sys_clk);
    t_write; t_status; t_read(8'h20, 1'h0); t_read(8'h40, 1'h1); t_wp; close_out;
  end
endmodule // sepi_core_tb_top
bind sepi_core sepi_core_sva chk (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .sck(sck),
  .hold_n(hold_n), .wp_n(wp_n), .so_q(so_q), .so_oe_n_q(so_oe_n_q), .mem_we_q(mem_we_q),
  .write_enable_latch_bit_q(write_enable_latch_bit_q), .busy_q(busy_q), .standby_q(standby_q));
